// ### bpr_top.sv
// Per-block power-down and reset distribution with its Wishbone register file.
`timescale 1ns/100ps
module bpr_top (
	input wire logic clk_i, // Core clock, 100 MHz.
	input wire logic rst_i, // Host bus reset, synchronous, active high.
	input wire logic core_por_i, // Core power-on reset, active high.
	input wire logic aux_por_i, // Auxiliary supply power-on reset, active high.
	input wire logic wb_cyc_i, // Wishbone cycle.
	input wire logic wb_stb_i, // Wishbone strobe.
	input wire logic wb_we_i, // Wishbone write enable.
	input wire logic [7:0] wb_adr_i, // Wishbone byte address.
	input wire logic [3:0] wb_sel_i, // Wishbone byte selects.
	input wire logic [31:0] wb_dat_i, // Wishbone write data.
	output logic [31:0] wb_dat_o, // Wishbone read data.
	output logic wb_ack_o, // Wishbone acknowledge.
	input wire logic codec_link_bit_clock_i, // Link bit clock pin.
	input wire logic codec_link_data_in_primary_i, // Primary link data pin.
	input wire logic codec_link_data_in_secondary_i, // Secondary link data pin.
	input wire logic midi_serial_in_i, // MIDI input pin.
	output logic codec_link_sync_o, // Link sync pin.
	output logic codec_link_data_out_o, // Link data out pin.
	output logic midi_serial_out_o, // MIDI output pin.
	output logic eeprom_clock_pin_o, // EEPROM clock output.
	output logic eeprom_clock_pin_oe_n_o, // EEPROM clock enable, low drives.
	output logic eeprom_data_pin_o, // EEPROM data output.
	output logic eeprom_data_pin_oe_n_o, // EEPROM data enable, low drives.
	output logic vol_pins_gpio_o, // Volume pins follow GPIO register.
	output logic [7:0] vol_gpio_o, // GPIO register value for volume pins.
	output logic joy_discharge_o, // Joystick discharge gate on.
	output logic joy_analog_on_o, // Joystick comparators and reference on.
	output logic joy_pullup_on_o, // Joystick button pull-ups on.
	output logic dll_clock_en_o, // DLL high-frequency clock enable.
	output logic sound_ctrl_rst_o, // Sound system controller reset.
	output logic playback_rate_converter_rst_o, // Playback rate converter reset.
	output logic capture_rate_converter_rst_o, // Capture rate converter reset.
	output logic joy_rst_o, // Joystick registers reset.
	output logic midi_rst_o, // MIDI state reset.
	output logic midi_clock_en_o, // MIDI clock enable.
	output logic hvol_rst_o, // Hardware volume reset.
	output logic link_rst_o, // Link engine reset.
	output logic dma_rst_o, // DMA and primary-window reset.
	output logic cfg_rst_o, // Config-space registers reset.
	output logic eeprom_rst_o, // EEPROM engine reset.
	output logic eeprom_probe_o, // One-cycle EEPROM probe request.
	output logic fm_rst_o, // FM synthesizer reset.
	output logic fm_clock_en_o, // FM clock enable.
	output logic fm_access_en_o, // FM register accesses accepted.
	output logic joy_write_en_o, // Joystick register writes accepted.
	output logic win_access_en_o // Memory window accesses accepted.
);
	logic full_power_down;
	logic [1:0] power_state_field;
	logic [7:0] aux_test;
	logic [7:0] aux_wake;
	logic dll_power_on;
	logic core_soft_clock_enable;
	logic playback_rate_conv_enable;
	logic capture_rate_conv_enable;
	logic joystick_enable;
	logic codec_link_enable;
	logic fm_synth_enable;
	logic hw_volume_enable;
	logic midi_transmit_enable;
	logic midi_receive_enable;
	logic eeprom_power_down;
	logic [7:0] gpio_control_register;
	logic fpd_prev;
	logic [4:0] bclk_cnt;
	logic bclk_present;
	logic bclk_last;
	logic [3:0] pins_s;
	logic bclk_s;
	logic core_reset;
	logic soft_reset;
	logic sound_down;
	logic link_down;
	logic acc;
	logic wr;
	logic [31:0] next_dat;
	logic [31:0] wmask;
	logic [31:0] wdata;

	bpr_sync #(
		.W(4)
	) u_sync (
		.clk_i(clk_i),
		.d_i({codec_link_bit_clock_i, codec_link_data_in_primary_i,
			codec_link_data_in_secondary_i, midi_serial_in_i}),
		.q_o(pins_s)
	);
	assign bclk_s = pins_s[3];

	// Merges write data under byte selects so only enabled lanes change.
	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
		input logic [3:0] sel);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++) begin
			if (sel[i]) begin
				r[i*8 +: 8] = nw[i*8 +: 8];
			end
		end
		return r;
	endfunction : merge

	assign core_reset = rst_i | core_por_i;
	assign soft_reset = core_reset | full_power_down;
	assign acc = wb_cyc_i & wb_stb_i & ~wb_ack_o & ~core_reset;
	// All fields sit in byte lane 0, so a write without that lane changes nothing.
	assign wr = acc & wb_we_i & wb_sel_i[0];
	assign wmask = {32{1'b0}};
	assign wdata = merge(wmask, wb_dat_i, wb_sel_i);

	// Auxiliary group: each reset source clears only its own share of bits.
	// Full power-down never touches this group; config access stays served.
	always_ff @(posedge clk_i) begin
		if (aux_por_i || rst_i || core_por_i) begin
			full_power_down <= 1'b0;
		end else if (wr && wb_adr_i == bpr_pkg::ADDR_AUX_PM) begin
			full_power_down <= wdata[bpr_pkg::AUX_FPD_BIT];
		end
	end

	// The power-state field survives a bus reset.
	always_ff @(posedge clk_i) begin
		if (aux_por_i || core_por_i) begin
			power_state_field <= bpr_pkg::PS_RESET;
		end else if (wr && wb_adr_i == bpr_pkg::ADDR_AUX_PM) begin
			power_state_field <= wdata[bpr_pkg::AUX_PS_LSB +: 2];
		end
	end

	// Bus reset clears the test register and the full power-down bit, but no other auxiliary bit.
	always_ff @(posedge clk_i) begin
		if (aux_por_i || rst_i) begin
			aux_test <= bpr_pkg::TEST_RESET;
		end else if (wr && wb_adr_i == bpr_pkg::ADDR_AUX_TEST) begin
			aux_test <= wdata[7:0];
		end
	end

	// Only the supply's own power-on reset clears the wake register.
	always_ff @(posedge clk_i) begin
		if (aux_por_i) begin
			aux_wake <= bpr_pkg::WAKE_RESET;
		end else if (wr && wb_adr_i == bpr_pkg::ADDR_AUX_WAKE) begin
			aux_wake <= wdata[7:0];
		end
	end

	// Primary-window control bits, reset by power-down and both core resets.
	always_ff @(posedge clk_i) begin
		if (soft_reset) begin
			dll_power_on <= 1'b0;
			core_soft_clock_enable <= 1'b0;
		end else if (wr && wb_adr_i == bpr_pkg::ADDR_CLK_CTRL) begin
			dll_power_on <= wdata[bpr_pkg::CLK_DLL_BIT];
			core_soft_clock_enable <= wdata[bpr_pkg::CLK_SWE_BIT];
		end
	end

	always_ff @(posedge clk_i) begin
		if (soft_reset) begin
			playback_rate_conv_enable <= 1'b0;
			capture_rate_conv_enable <= 1'b0;
			joystick_enable <= 1'b0;
			codec_link_enable <= 1'b0;
			fm_synth_enable <= 1'b0;
			hw_volume_enable <= 1'b0;
		end else if (wr && wb_adr_i == bpr_pkg::ADDR_SUB_EN) begin
			playback_rate_conv_enable <= wdata[bpr_pkg::EN_PLAYBACK_RATE_CONVERTER_BIT];
			capture_rate_conv_enable <= wdata[bpr_pkg::EN_CAPTURE_RATE_CONVERTER_BIT];
			joystick_enable <= wdata[bpr_pkg::EN_JOY_BIT];
			codec_link_enable <= wdata[bpr_pkg::EN_LINK_BIT];
			fm_synth_enable <= wdata[bpr_pkg::EN_FM_BIT];
			hw_volume_enable <= wdata[bpr_pkg::EN_HVC_BIT];
		end
	end

	always_ff @(posedge clk_i) begin
		if (soft_reset) begin
			midi_transmit_enable <= 1'b0;
			midi_receive_enable <= 1'b0;
			eeprom_power_down <= 1'b0;
		end else if (wr && wb_adr_i == bpr_pkg::ADDR_MISC_CTRL) begin
			midi_transmit_enable <= wdata[bpr_pkg::MISC_MTX_BIT];
			midi_receive_enable <= wdata[bpr_pkg::MISC_MRX_BIT];
			eeprom_power_down <= wdata[bpr_pkg::MISC_EEPD_BIT];
		end
	end

	always_ff @(posedge clk_i) begin
		if (soft_reset) begin
			gpio_control_register <= bpr_pkg::GPIO_RESET;
		end else if (wr && wb_adr_i == bpr_pkg::ADDR_GPIO_CTRL) begin
			gpio_control_register <= wdata[7:0];
		end
	end

	// Bit clock watchdog: the clock counts as lost after a quiet spell of core cycles.
	// A bit clock slower than the timeout is taken for a lost one; the count trades
	// detection speed against the slowest link rate that can still be carried.
	always_ff @(posedge clk_i) begin
		if (core_reset) begin
			bclk_last <= 1'b0;
			bclk_cnt <= 5'h00;
			bclk_present <= 1'b0;
		end else begin
			bclk_last <= bclk_s;
			if (bclk_s != bclk_last) begin
				bclk_cnt <= 5'h00;
				bclk_present <= 1'b1;
			end else if (bclk_cnt == 5'(bpr_pkg::BCLK_TIMEOUT)) begin
				bclk_present <= 1'b0;
			end else begin
				bclk_cnt <= bclk_cnt + 5'h01;
			end
		end
	end

	// EEPROM probe on falling edge of full power-down.
	always_ff @(posedge clk_i) begin
		if (core_reset) begin
			fpd_prev <= 1'b0;
			eeprom_probe_o <= 1'b0;
		end else begin
			fpd_prev <= full_power_down;
			eeprom_probe_o <= fpd_prev & ~full_power_down;
		end
	end

	// A hold is a level over every source, so it rises in the same cycle as the reset or
	// power-down instead of one cycle later when the cleared enable bit shows.
	function automatic logic held(input logic enable, input logic force_down);
		return ~enable | force_down;
	endfunction : held

	// Hold-down levels for every sub-block.
	// Outputs that open a sub-block are the inverse of its hold, except win_access_en_o, which follows full power-down only, and joy_pullup_on_o, tied high.
	assign sound_down = ~dll_power_on | ~core_soft_clock_enable | ~bclk_present;
	assign sound_ctrl_rst_o = sound_down | soft_reset;
	assign dll_clock_en_o = ~sound_ctrl_rst_o;
	assign playback_rate_converter_rst_o = held(playback_rate_conv_enable, soft_reset);
	assign capture_rate_converter_rst_o = held(capture_rate_conv_enable, soft_reset);
	assign joy_rst_o = held(joystick_enable, soft_reset);
	assign joy_write_en_o = ~joy_rst_o;
	assign joy_discharge_o = ~joy_rst_o;
	assign joy_analog_on_o = ~joy_rst_o;
	assign joy_pullup_on_o = 1'b1;
	assign midi_rst_o = held(midi_transmit_enable | midi_receive_enable, soft_reset);
	assign midi_clock_en_o = ~midi_rst_o;
	assign hvol_rst_o = held(hw_volume_enable, soft_reset);
	assign vol_pins_gpio_o = hvol_rst_o;
	assign vol_gpio_o = gpio_control_register;
	// Link stays independent of the sound system so codec accesses still work.
	assign link_down = held(codec_link_enable & bclk_present, soft_reset);
	assign link_rst_o = link_down;
	assign dma_rst_o = soft_reset;
	assign cfg_rst_o = core_reset;
	assign win_access_en_o = ~full_power_down;
	assign eeprom_rst_o = eeprom_power_down | soft_reset;
	assign eeprom_clock_pin_oe_n_o = 1'b1;
	assign eeprom_data_pin_oe_n_o = 1'b1;
	assign fm_rst_o = held(fm_synth_enable & ~sound_down, soft_reset);
	assign fm_clock_en_o = ~fm_rst_o;
	assign fm_access_en_o = ~fm_rst_o;

	// Pin outputs registered; data pins ignored while their block is down.
	always_ff @(posedge clk_i) begin
		if (core_reset) begin
			codec_link_sync_o <= 1'b0;
			codec_link_data_out_o <= 1'b0;
			midi_serial_out_o <= 1'b1;
			eeprom_clock_pin_o <= 1'b0;
			eeprom_data_pin_o <= 1'b0;
		end else begin
			// The link engine itself lives elsewhere; here its pins are only forced.
			codec_link_sync_o <= 1'b0;
			codec_link_data_out_o <= link_down ? 1'b0 :
				(pins_s[2] ^ pins_s[1]);
			midi_serial_out_o <= midi_rst_o ? 1'b1 : pins_s[0];
			eeprom_clock_pin_o <= 1'b0;
			eeprom_data_pin_o <= 1'b0;
		end
	end

	// Read mux: status shows live hold-down levels.
	always_comb begin
		next_dat = bpr_pkg::READ_ZERO;
		unique case (wb_adr_i)
			bpr_pkg::ADDR_AUX_PM: next_dat[2:0] = {power_state_field, full_power_down};
			bpr_pkg::ADDR_CLK_CTRL: next_dat[1:0] = {core_soft_clock_enable, dll_power_on};
			bpr_pkg::ADDR_SUB_EN: next_dat[5:0] = {hw_volume_enable, fm_synth_enable,
				codec_link_enable, joystick_enable, capture_rate_conv_enable,
				playback_rate_conv_enable};
			bpr_pkg::ADDR_MISC_CTRL: next_dat[2:0] = {eeprom_power_down,
				midi_receive_enable, midi_transmit_enable};
			bpr_pkg::ADDR_STATUS: next_dat[8:0] = {bclk_present, fm_rst_o, eeprom_rst_o,
				link_rst_o, hvol_rst_o, midi_rst_o, joy_rst_o, sound_ctrl_rst_o,
				dma_rst_o};
			bpr_pkg::ADDR_AUX_TEST: next_dat[7:0] = aux_test;
			bpr_pkg::ADDR_AUX_WAKE: next_dat[7:0] = aux_wake;
			bpr_pkg::ADDR_GPIO_CTRL: next_dat[7:0] = gpio_control_register;
			default: next_dat = bpr_pkg::READ_ZERO;
		endcase
	end

	// One-wait-state slave; no answer at all while a core reset is active.
	// Ack is registered and drops by itself in the cycle after it was given.
	always_ff @(posedge clk_i) begin
		if (core_reset) begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= bpr_pkg::READ_ZERO;
		end else begin
			wb_ack_o <= acc;
			if (acc && !wb_we_i) begin
				wb_dat_o <= next_dat;
			end
		end
	end
endmodule : bpr_top

// ### bpr_pkg.sv
// Package with register map, field positions and reset values of the power-down and reset control.
package bpr_pkg;
	localparam logic [7:0] ADDR_AUX_PM = 8'h00;
	localparam logic [7:0] ADDR_CLK_CTRL = 8'h04;
	localparam logic [7:0] ADDR_SUB_EN = 8'h08;
	localparam logic [7:0] ADDR_MISC_CTRL = 8'h0C;
	localparam logic [7:0] ADDR_STATUS = 8'h10;
	localparam logic [7:0] ADDR_AUX_TEST = 8'h14;
	localparam logic [7:0] ADDR_AUX_WAKE = 8'h18;
	localparam logic [7:0] ADDR_GPIO_CTRL = 8'h1C;
	localparam int AUX_FPD_BIT = 0;
	localparam int AUX_PS_LSB = 1;
	localparam int CLK_DLL_BIT = 0;
	localparam int CLK_SWE_BIT = 1;
	localparam int EN_PLAYBACK_RATE_CONVERTER_BIT = 0;
	localparam int EN_CAPTURE_RATE_CONVERTER_BIT = 1;
	localparam int EN_JOY_BIT = 2;
	localparam int EN_LINK_BIT = 3;
	localparam int EN_FM_BIT = 4;
	localparam int EN_HVC_BIT = 5;
	localparam int MISC_MTX_BIT = 0;
	localparam int MISC_MRX_BIT = 1;
	localparam int MISC_EEPD_BIT = 2;
	localparam logic [1:0] PS_RESET = 2'h0;
	localparam logic [7:0] TEST_RESET = 8'h00;
	localparam logic [7:0] WAKE_RESET = 8'h00;
	localparam logic [7:0] GPIO_RESET = 8'h00;
	localparam logic [31:0] READ_ZERO = 32'h0000_0000;
	localparam int BCLK_TIMEOUT = 16;
endpackage : bpr_pkg

// ### bpr_sync.sv
// Two-flop synchroniser for a group of pin inputs.
`timescale 1ns/100ps
module bpr_sync #(
	parameter int W = 1
) (
	input wire logic clk_i, // Core clock.
	input wire logic [W-1:0] d_i, // Asynchronous inputs.
	output logic [W-1:0] q_o // Synchronised outputs.
);
	logic [W-1:0] stage1;
	always_ff @(posedge clk_i) begin
		stage1 <= d_i;
		q_o <= stage1;
	end
endmodule : bpr_sync

// ### bpr_top_assertions.sv
// Port-level checks of the power-down and reset control.
`timescale 1ns/100ps
module bpr_top_assertions (
	input wire logic clk_i, // Core clock.
	input wire logic rst_i, // Host bus reset.
	input wire logic core_por_i, // Core power-on reset.
	input wire logic aux_por_i, // Aux power-on reset.
	input wire logic wb_ack_o, // Bus acknowledge.
	input wire logic win_access_en_o, // Window access.
	input wire logic dma_rst_o, // DMA reset.
	input wire logic dll_clock_en_o, // DLL clock enable.
	input wire logic sound_ctrl_rst_o, // Sound controller reset.
	input wire logic fm_rst_o, // FM reset.
	input wire logic fm_clock_en_o, // FM clock enable.
	input wire logic midi_rst_o, // MIDI reset.
	input wire logic midi_serial_out_o, // MIDI output.
	input wire logic link_rst_o, // Link reset.
	input wire logic codec_link_sync_o, // Link sync.
	input wire logic codec_link_data_out_o, // Link data out.
	input wire logic eeprom_rst_o, // EEPROM reset.
	input wire logic eeprom_clock_pin_oe_n_o, // EEPROM clock enable.
	input wire logic eeprom_probe_o, // EEPROM probe.
	input wire logic joy_rst_o, // Joystick reset.
	input wire logic joy_discharge_o, // Discharge gate.
	input wire logic joy_pullup_on_o, // Button pull-ups.
	input wire logic hvol_rst_o, // Volume reset.
	input wire logic vol_pins_gpio_o // Volume pins on GPIO.
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i || core_por_i);
	win_hold_a: assert property (!win_access_en_o |-> dma_rst_o && eeprom_rst_o)
		else $error("window open or EEPROM live in power-down");
	no_ack_rst_a: assert property (disable iff (aux_por_i)
		(rst_i || core_por_i) |=> !wb_ack_o) else $error("ack during reset");
	sound_hold_a: assert property (!dll_clock_en_o |-> sound_ctrl_rst_o && fm_rst_o)
		else $error("sound down without holds");
	fm_off_a: assert property (fm_rst_o |-> !fm_clock_en_o)
		else $error("FM clock runs in reset");
	midi_off_a: assert property (midi_rst_o ##1 midi_rst_o |-> midi_serial_out_o)
		else $error("MIDI output not high");
	link_off_a: assert property (link_rst_o ##1 link_rst_o |->
		!codec_link_data_out_o && !codec_link_sync_o) else $error("link pins not low");
	eeprom_rel_a: assert property (eeprom_rst_o |-> eeprom_clock_pin_oe_n_o)
		else $error("EEPROM pin driven in reset");
	joy_off_a: assert property (joy_rst_o |-> !joy_discharge_o && joy_pullup_on_o)
		else $error("joystick pins wrong when off");
	hvol_gpio_a: assert property (hvol_rst_o |-> vol_pins_gpio_o)
		else $error("volume pins not on GPIO");
	probe_after_a: assert property ($rose(win_access_en_o) |-> ##[0:3] eeprom_probe_o)
		else $error("no EEPROM probe");
endmodule : bpr_top_assertions

bind bpr_top bpr_top_assertions u_bpr_top_assertions (.clk_i, .rst_i, .core_por_i, .aux_por_i,
	.wb_ack_o, .win_access_en_o, .dma_rst_o, .dll_clock_en_o, .sound_ctrl_rst_o, .fm_rst_o,
	.fm_clock_en_o, .midi_rst_o, .midi_serial_out_o, .link_rst_o, .codec_link_sync_o,
	.codec_link_data_out_o, .eeprom_rst_o, .eeprom_clock_pin_oe_n_o, .eeprom_probe_o,
	.joy_rst_o, .joy_discharge_o, .joy_pullup_on_o, .hvol_rst_o, .vol_pins_gpio_o);

// ### bpr_far_model.sv
// Far-side pin model: link bit clock, link data inputs and MIDI input.
`timescale 1ns/100ps
module bpr_far_model (
	input wire logic run_i, // Bit clock runs while high.
	output logic bclk_o, // Link bit clock.
	output logic din_prim_o, // Primary link data.
	output logic din_sec_o, // Secondary link data.
	output logic midi_o // MIDI line.
);
	logic [3:0] pat;
	// The clock stands still when stopped, so the device must notice it has gone.
	initial begin
		bclk_o = 1'b0;
		pat = 4'h5;
		forever begin
			#41;
			if (run_i) begin
				bclk_o = ~bclk_o;
				pat = {pat[2:0], ~pat[3]};
			end
		end
	end
	assign din_prim_o = pat[0];
	assign din_sec_o = pat[1];
	assign midi_o = pat[2];
endmodule : bpr_far_model

// ### test_block_powerdown_reset_control.sv
// Self-checking bench for the block power-down and reset control.
`timescale 1ns/100ps
module test_block_powerdown_reset_control;
	logic clk_i, rst_i, core_por_i, aux_por_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
	logic [7:0] wb_adr_i, vol_gpio_o;
	logic [3:0] wb_sel_i;
	logic [31:0] wb_dat_i, wb_dat_o;
	logic codec_link_bit_clock_i, codec_link_data_in_primary_i, codec_link_data_in_secondary_i;
	logic midi_serial_in_i, codec_link_sync_o, codec_link_data_out_o, midi_serial_out_o;
	logic eeprom_clock_pin_o, eeprom_clock_pin_oe_n_o, eeprom_data_pin_o, eeprom_data_pin_oe_n_o;
	logic vol_pins_gpio_o, joy_discharge_o, joy_analog_on_o, joy_pullup_on_o, dll_clock_en_o;
	logic sound_ctrl_rst_o, playback_rate_converter_rst_o, capture_rate_converter_rst_o, joy_rst_o, midi_rst_o, midi_clock_en_o;
	logic hvol_rst_o, link_rst_o, dma_rst_o, cfg_rst_o, eeprom_rst_o, eeprom_probe_o, fm_rst_o;
	logic fm_clock_en_o, fm_access_en_o, joy_write_en_o, win_access_en_o, far_run;
	int err_total, comparisons;
	int probe_cnt = 0;
	int probe_base;

	bpr_top u_bpr_top (.clk_i, .rst_i, .core_por_i, .aux_por_i, .wb_cyc_i, .wb_stb_i, .wb_we_i,
		.wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .codec_link_bit_clock_i,
		.codec_link_data_in_primary_i, .codec_link_data_in_secondary_i, .midi_serial_in_i,
		.codec_link_sync_o, .codec_link_data_out_o, .midi_serial_out_o, .eeprom_clock_pin_o,
		.eeprom_clock_pin_oe_n_o, .eeprom_data_pin_o, .eeprom_data_pin_oe_n_o, .vol_pins_gpio_o,
		.vol_gpio_o, .joy_discharge_o, .joy_analog_on_o, .joy_pullup_on_o, .dll_clock_en_o,
		.sound_ctrl_rst_o, .playback_rate_converter_rst_o, .capture_rate_converter_rst_o, .joy_rst_o, .midi_rst_o, .midi_clock_en_o,
		.hvol_rst_o, .link_rst_o, .dma_rst_o, .cfg_rst_o, .eeprom_rst_o, .eeprom_probe_o,
		.fm_rst_o, .fm_clock_en_o, .fm_access_en_o, .joy_write_en_o, .win_access_en_o);
	bpr_far_model u_bpr_far_model (.run_i(far_run), .bclk_o(codec_link_bit_clock_i),
		.din_prim_o(codec_link_data_in_primary_i), .din_sec_o(codec_link_data_in_secondary_i),
		.midi_o(midi_serial_in_i));

	initial begin
		clk_i = 1'b0;
		forever #5 clk_i = ~clk_i;
	end
	always @(posedge clk_i) if (eeprom_probe_o === 1'b1) probe_cnt <= probe_cnt + 1;

	task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp) begin
			err_total++;
			$display("ERROR %0t read %h expected %h", $time, got, exp);
		end
	endtask : chk_word
	task automatic chk_bit(input logic got, input logic exp);
		comparisons++;
		if (got !== exp) begin
			err_total++;
			$display("ERROR %0t pin %b expected %b", $time, got, exp);
		end
	endtask : chk_bit
	// Waits for the ack with no count of its own; only the watchdog ends a hang.
	task automatic wb_xfer(input logic we, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] q);
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i <= we;
		wb_adr_i <= a;
		wb_dat_i <= d;
		do @(posedge clk_i); while (wb_ack_o !== 1'b1);
		q = wb_dat_o;
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
		@(posedge clk_i);
	endtask : wb_xfer
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] q;
		wb_xfer(1'b1, a, d, q);
	endtask : wr
	task automatic rd(input logic [7:0] a, input logic [31:0] exp);
		logic [31:0] q;
		wb_xfer(1'b0, a, 32'h0000_0000, q);
		chk_word(q, exp);
	endtask : rd
	task automatic hit(input logic [2:0] m);
		{aux_por_i, core_por_i, rst_i} <= m;
		repeat (2) @(posedge clk_i);
		{aux_por_i, core_por_i, rst_i} <= 3'h0;
		@(posedge clk_i);
	endtask : hit
	task automatic end_of_test;
		$display("Comparisons %0d errors %0d", comparisons, err_total);
		if (err_total == 0 && comparisons > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask : end_of_test

	initial begin
		#60000;
		err_total++;
		$display("ERROR %0t watchdog expired", $time);
		end_of_test();
	end

	initial begin
		{err_total, comparisons} = 0;
		{rst_i, aux_por_i, core_por_i, wb_cyc_i, wb_stb_i, wb_we_i} = 6'h31;
		{wb_adr_i, wb_dat_i, wb_sel_i, far_run} = 0;
		rst_i = 1'b1;
		aux_por_i = 1'b1;
		far_run = 1'b1;
		wb_sel_i = 4'hF;
		repeat (8) @(posedge clk_i);
		{aux_por_i, rst_i} <= 2'h0;
		@(posedge clk_i);
		rd(8'h00, 32'h0000_0000);
		rd(8'h08, 32'h0000_0000);
		chk_bit(midi_serial_out_o, 1'b1);
		chk_bit(eeprom_clock_pin_oe_n_o, 1'b1);
		wr(8'h04, 32'h0000_0003);
		wr(8'h08, 32'h0000_003F);
		wr(8'h0C, 32'h0000_0003);
		chk_bit(dll_clock_en_o, 1'b1);
		chk_bit(joy_write_en_o, 1'b1);
		chk_bit(midi_clock_en_o, 1'b1);
		chk_bit(fm_clock_en_o, 1'b1);
		chk_bit(eeprom_rst_o, 1'b0);
		chk_bit(fm_rst_o, 1'b0);
		chk_bit(vol_pins_gpio_o, 1'b0);
		wr(8'h08, 32'h0000_003E);
		chk_bit(playback_rate_converter_rst_o, 1'b1);
		chk_bit(capture_rate_converter_rst_o, 1'b0);
		wr(8'h04, 32'h0000_0001);
		chk_bit(dll_clock_en_o, 1'b0);
		chk_bit(fm_rst_o, 1'b1);
		chk_bit(link_rst_o, 1'b0);
		wr(8'h14, 32'h0000_005A);
		wr(8'h18, 32'h0000_00A5);
		wr(8'h1C, 32'h0000_0033);
		chk_word(32'(vol_gpio_o), 32'h0000_0033);
		wr(8'h00, 32'h0000_0007);
		rd(8'h08, 32'h0000_0000);
		rd(8'h1C, 32'h0000_0000);
		chk_bit(win_access_en_o, 1'b0);
		chk_bit(dma_rst_o, 1'b1);
		chk_bit(cfg_rst_o, 1'b0);
		chk_bit(eeprom_rst_o, 1'b1);
		chk_bit(joy_write_en_o, 1'b0);
		chk_bit(fm_access_en_o, 1'b0);
		chk_bit(playback_rate_converter_rst_o, 1'b1);
		wr(8'h08, 32'h0000_003F);
		rd(8'h08, 32'h0000_0000);
		rd(8'h14, 32'h0000_005A);
		probe_base = probe_cnt;
		wr(8'h00, 32'h0000_0006);
		repeat (3) @(posedge clk_i);
		chk_word(32'(probe_cnt - probe_base), 32'h0000_0001);
		hit(3'h2);
		rd(8'h00, 32'h0000_0000);
		rd(8'h14, 32'h0000_005A);
		wr(8'h1C, 32'h0000_0033);
		wr(8'h00, 32'h0000_0006);
		hit(3'h1);
		rd(8'h00, 32'h0000_0006);
		rd(8'h14, 32'h0000_0000);
		rd(8'h18, 32'h0000_00A5);
		rd(8'h1C, 32'h0000_0000);
		wb_sel_i <= 4'hE;
		wr(8'h1C, 32'h0000_00FF);
		wb_sel_i <= 4'hF;
		rd(8'h1C, 32'h0000_0000);
		hit(3'h4);
		rd(8'h18, 32'h0000_0000);
		rd(8'h00, 32'h0000_0000);
		rd(8'h40, 32'h0000_0000);
		wr(8'h08, 32'h0000_0008);
		far_run <= 1'b0;
		repeat (40) @(posedge clk_i);
		chk_bit(link_rst_o, 1'b1);
		chk_bit(codec_link_data_out_o, 1'b0);
		chk_bit(codec_link_sync_o, 1'b0);
		rd(8'h10, 32'h0000_00BE);
		end_of_test();
	end
endmodule : test_block_powerdown_reset_control
